// [shared/mmc_defs.svh]
// Constants for the module management control block
`ifndef MMC_DEFS_SVH
`define MMC_DEFS_SVH
`define MMC_DEV_ADDR 7'h50
`define MMC_PAGE_SEL_OFS 8'h7F
`define MMC_RSVD_A_OFS 8'h77
`define MMC_RSVD_B_OFS 8'h7B
`define MMC_STATUS_OFS 8'h02
`define MMC_FLAG_OFS 8'h03
`define MMC_CTRL_OFS 8'h56
`define MMC_LOWER_SIZE 128
`define MMC_PAGE_COUNT 4
`define MMC_PAGE_SEL_RST 8'h00
`define MMC_STATUS_NOT_READY_BIT 0
`define MMC_CTRL_LOW_POWER_BIT 0
`define MMC_CLK_MHZ 250
`define MMC_RESET_MIN_US 2
`define MMC_RESET_MIN_CYC (`MMC_RESET_MIN_US * `MMC_CLK_MHZ + 1)
`define MMC_INIT_MS 2000
`define MMC_INIT_CYC (`MMC_INIT_MS * 1000 * `MMC_CLK_MHZ)
`endif

// [shared/mmc_pkg.sv]
// Types for the module management control block
package mmc_pkg;
  typedef enum logic [2:0] {MMC_IDLE, MMC_ADDR, MMC_ADDR_ACK, MMC_WR, MMC_WR_ACK, MMC_RD, MMC_RD_ACK} mmc_bus_state_t;
  typedef enum logic [1:0] {MMC_RST_HOLD, MMC_INIT, MMC_READY} mmc_init_state_t;
endpackage : mmc_pkg

// [shared/mmc_mem_if.sv]
// Byte access path between the serial engine and the memory
`timescale 1ns/1ps
interface mmc_mem_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport memory (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : mmc_mem_if

// [hw/mmc_serial.sv]
// Two-wire serial slave engine
`timescale 1ns/1ps
`include "mmc_defs.svh"
module mmc_serial
  import mmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic selected,
  output logic sda_oe,
  mmc_mem_if.engine mem
);
  logic scl_d_r;
  logic sda_d_r;
  mmc_bus_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] ptr_r;
  logic first_r;
  logic rd_mode_r;
  logic [7:0] out_r;
  logic oe_r;
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_seen = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_seen = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire byte_done = bit_cnt_r == 4'h8;
  wire addr_hit = shift_r[7:1] == `MMC_DEV_ADDR;
  assign sda_oe = oe_r;
  assign mem.addr = ptr_r;
  assign mem.wdata = shift_r;
  assign mem.wr_en = ce && scl_fall && state_r == MMC_WR && byte_done && !first_r;
  assign mem.rd_en = 1'b0;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= MMC_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      ptr_r <= 8'h00;
      first_r <= 1'b0;
      rd_mode_r <= 1'b0;
      out_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else if (ce)
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (!selected || stop_seen)
      begin
        state_r <= MMC_IDLE;
        oe_r <= 1'b0;
      end
      else if (start_seen)
      begin
        state_r <= MMC_ADDR;
        bit_cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end
      else if (scl_rise && state_r inside {MMC_ADDR, MMC_WR})
      begin
        shift_r <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      else if (scl_rise && state_r == MMC_RD_ACK && sda_s)
        state_r <= MMC_IDLE;
      else if (scl_fall)
      begin
        unique case (state_r)
          MMC_IDLE: oe_r <= 1'b0;
          MMC_ADDR:
            if (byte_done && addr_hit)
            begin
              state_r <= MMC_ADDR_ACK;
              rd_mode_r <= shift_r[0];
              oe_r <= 1'b1;
            end
            else if (byte_done)
              state_r <= MMC_IDLE;
          MMC_ADDR_ACK:
          begin
            bit_cnt_r <= 4'h0;
            first_r <= 1'b1;
            if (rd_mode_r)
            begin
              state_r <= MMC_RD;
              out_r <= {mem.rdata[6:0], 1'b0};
              oe_r <= !mem.rdata[7];
              bit_cnt_r <= 4'h1;
            end
            else
            begin
              state_r <= MMC_WR;
              oe_r <= 1'b0;
            end
          end
          MMC_WR:
            if (byte_done)
            begin
              if (first_r)
                ptr_r <= shift_r;
              else
                ptr_r <= ptr_r + 8'h01;
              first_r <= 1'b0;
              state_r <= MMC_WR_ACK;
              oe_r <= 1'b1;
            end
          MMC_WR_ACK:
          begin
            state_r <= MMC_WR;
            bit_cnt_r <= 4'h0;
            oe_r <= 1'b0;
          end
          MMC_RD:
            if (byte_done)
            begin
              state_r <= MMC_RD_ACK;
              ptr_r <= ptr_r + 8'h01;
              oe_r <= 1'b0;
            end
            else
            begin
              oe_r <= !out_r[7];
              out_r <= {out_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          MMC_RD_ACK:
          begin
            state_r <= MMC_RD;
            out_r <= {mem.rdata[6:0], 1'b0};
            oe_r <= !mem.rdata[7];
            bit_cnt_r <= 4'h1;
          end
        endcase
      end
    end
  end
endmodule : mmc_serial

// [hw/mmc_top.sv]
// Management side of a pluggable four-lane optical module
`timescale 1ns/1ps
`include "mmc_defs.svh"
module mmc_top
  import mmc_pkg::*;
#(
  parameter int unsigned INIT_CYC = `MMC_INIT_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic MODULE_PRESENT_N,
  output logic INTERRUPT_OUT_N,
  output logic INTERRUPT_OUT_OE,
  output logic LOW_POWER_STATE,
  input wire logic [7:0] FAULT_FLAGS
);
  logic [2:0] sel_sync_r;
  logic [2:0] rst_sync_r;
  logic [2:0] lp_sync_r;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [31:0] low_cnt_r;
  logic [31:0] init_cnt_r;
  mmc_init_state_t init_r;
  logic not_ready_r;
  logic int_r;
  logic [7:0] flags_r;
  logic [7:0] page_sel_r;
  logic [7:0] ctrl_r;
  logic [7:0] rdata_r;
  logic [7:0] lower_mem [0:`MMC_LOWER_SIZE-1];
  logic [7:0] upper_mem [0:`MMC_PAGE_COUNT*128-1];
  mmc_mem_if mem_if ();
  wire mod_rst_n = rst_sync_r[2];
  wire selected = !sel_sync_r[2];
  wire soft_rst = init_r == MMC_RST_HOLD;
  wire [7:0] addr = mem_if.addr;
  wire upper = addr[7];
  wire [1:0] page_idx = page_sel_r[1:0];
  wire [8:0] upper_idx = {page_idx, addr[6:0]};
  wire hit_page = addr == `MMC_PAGE_SEL_OFS;
  wire hit_status = addr == `MMC_STATUS_OFS;
  wire hit_flags = addr == `MMC_FLAG_OFS;
  wire hit_ctrl = addr == `MMC_CTRL_OFS;
  wire rsvd_hit = addr[7:4] == 4'h7 && addr != `MMC_PAGE_SEL_OFS;
  wire [7:0] status_byte = {7'h00, not_ready_r};
  wire [7:0] rd_mux = upper ? upper_mem[upper_idx] : hit_page ? page_sel_r : hit_status ? status_byte :
    hit_flags ? flags_r : hit_ctrl ? ctrl_r : rsvd_hit ? 8'h00 : lower_mem[addr[6:0]];
  assign mem_if.rdata = rdata_r;
  assign MODULE_PRESENT_N = 1'b0;
  assign SDA_OUT = 1'b0;
  assign INTERRUPT_OUT_N = 1'b0;
  assign INTERRUPT_OUT_OE = int_r;
  assign LOW_POWER_STATE = lp_sync_r[2] || ctrl_r[`MMC_CTRL_LOW_POWER_BIT];
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      sel_sync_r <= 3'b111;
      rst_sync_r <= 3'b111;
      lp_sync_r <= 3'b000;
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
    end
    else if (CE)
    begin
      sel_sync_r <= {sel_sync_r[1:0], MODULE_SELECT_N};
      rst_sync_r <= {rst_sync_r[1:0], MODULE_RESET_N};
      lp_sync_r <= {lp_sync_r[1:0], LOW_POWER_REQUEST};
      scl_sync_r <= {scl_sync_r[0], SCL};
      sda_sync_r <= {sda_sync_r[0], SDA_IN};
    end
  end
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      init_r <= MMC_RST_HOLD;
      low_cnt_r <= 32'h0;
      init_cnt_r <= 32'h0;
      not_ready_r <= 1'b1;
      int_r <= 1'b0;
      flags_r <= 8'h00;
    end
    else if (CE)
    begin
      low_cnt_r <= mod_rst_n ? 32'h0 : low_cnt_r + 32'h1;
      if (!mod_rst_n && low_cnt_r >= 32'(`MMC_RESET_MIN_CYC))
      begin
        init_r <= MMC_RST_HOLD;
        not_ready_r <= 1'b1;
        int_r <= 1'b0;
        flags_r <= 8'h00;
      end
      else
      begin
        flags_r <= flags_r | FAULT_FLAGS;
        unique case (init_r)
          MMC_RST_HOLD:
            if (mod_rst_n)
            begin
              init_r <= MMC_INIT;
              init_cnt_r <= 32'h0;
            end
          MMC_INIT:
            if (init_cnt_r >= INIT_CYC - 1)
            begin
              init_r <= MMC_READY;
              not_ready_r <= 1'b0;
              int_r <= 1'b1;
            end
            else
              init_cnt_r <= init_cnt_r + 32'h1;
          MMC_READY:
            if (|FAULT_FLAGS)
              int_r <= 1'b1;
            else if (mem_if.wr_en && hit_flags)
              int_r <= 1'b0;
        endcase
        if (init_r == MMC_READY && mem_if.wr_en && hit_flags)
          flags_r <= FAULT_FLAGS;
      end
    end
  end
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N || soft_rst)
    begin
      page_sel_r <= `MMC_PAGE_SEL_RST;
      ctrl_r <= 8'h00;
      rdata_r <= 8'h00;
    end
    else if (CE)
    begin
      rdata_r <= rd_mux;
      if (mem_if.wr_en && hit_page)
        page_sel_r <= mem_if.wdata;
      if (mem_if.wr_en && hit_ctrl)
        ctrl_r <= mem_if.wdata;
    end
  end
  always_ff @(posedge REF_CLK)
  begin
    if (CE && mem_if.wr_en && !upper && !hit_page && !rsvd_hit)
      lower_mem[addr[6:0]] <= mem_if.wdata;
    if (CE && mem_if.wr_en && upper)
      upper_mem[upper_idx] <= mem_if.wdata;
  end
  mmc_serial u_serial (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .scl_s(scl_sync_r[1]),
    .sda_s(sda_sync_r[1]),
    .selected(selected),
    .sda_oe(SDA_OE),
    .mem(mem_if.engine)
  );
endmodule : mmc_top

// [tb/mmc_top_asserts.sv]
// Port checker for the management block
`timescale 1ns/1ps
module mmc_top_asserts
#(
  parameter int unsigned INIT_CYC = 100
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic MODULE_PRESENT_N,
  input wire logic INTERRUPT_OUT_N,
  input wire logic INTERRUPT_OUT_OE,
  input wire logic LOW_POWER_STATE,
  input wire logic [7:0] FAULT_FLAGS
);
  int unsigned up_r;
  // Cycles since release, saturating
  always_ff @(posedge REF_CLK)
    if (!RST_N || !MODULE_RESET_N)
      up_r <= 32'h0;
    else if (CE && up_r < INIT_CYC + 32'h8)
      up_r <= up_r + 32'h1;
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_sda_low: assert property (SDA_OUT == 1'b0) else $error("data pin not low");
  a_desel_quiet: assert property (MODULE_SELECT_N [*8] |-> !SDA_OE) else $error("driven unselected");
  a_rst_quiet: assert property ($rose(RST_N) |-> !SDA_OE && !INTERRUPT_OUT_OE) else $error("reset");
  a_init_wait: assert property ($rose(INTERRUPT_OUT_OE) |-> up_r >= INIT_CYC) else $error("early");
  a_lp_pin: assert property (LOW_POWER_REQUEST [*6] |-> LOW_POWER_STATE) else $error("low power");
  a_present_gnd: assert property (MODULE_PRESENT_N == 1'b0) else $error("presence");
  a_int_pin_low: assert property (INTERRUPT_OUT_N == 1'b0) else $error("interrupt level");
  a_fault_raise: assert property (up_r == INIT_CYC + 32'h8 && FAULT_FLAGS != 8'h00
    |-> ##[1:4] INTERRUPT_OUT_OE) else $error("fault not raised");
endmodule : mmc_top_asserts
bind mmc_top mmc_top_asserts #(.INIT_CYC(INIT_CYC)) mmc_top_asserts_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .CE(CE), .MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
  .LOW_POWER_REQUEST(LOW_POWER_REQUEST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .MODULE_PRESENT_N(MODULE_PRESENT_N), .INTERRUPT_OUT_N(INTERRUPT_OUT_N),
  .INTERRUPT_OUT_OE(INTERRUPT_OUT_OE), .LOW_POWER_STATE(LOW_POWER_STATE), .FAULT_FLAGS(FAULT_FLAGS));

// [tb/mmc_host_model.sv]
// Host-side two-wire bus master model
`timescale 1ns/1ps
module mmc_host_model
(
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Start or stop condition
  task automatic frame(input logic stop);
    sda_oe = stop;
    #8;
    scl = 1'b1;
    #8;
    sda_oe = !stop;
    #8;
    if (!stop)
      scl = 1'b0;
    #8;
  endtask : frame
  // One 32 ns bit, sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    sda_oe = !b;
    #8;
    scl = 1'b1;
    #15;
    r = sda;
    #1;
    scl = 1'b0;
    #8;
  endtask : bitx
  task automatic byte_x(input logic [7:0] b, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bitx(b[i], q[i]);
    bitx(1'b1, nak);
  endtask : byte_x
  task automatic xfer(input logic [7:0] dev, input logic [7:0] ptr, input logic wr, input logic [7:0] b,
    output logic [7:0] q, output logic ok);
    logic [7:0] j;
    logic n0, n1, n2;
    #1.1;
    frame(1'b0);
    byte_x(dev, j, n0);
    byte_x(ptr, j, n1);
    if (wr)
      byte_x(b, j, n2);
    else
    begin
      frame(1'b1);
      frame(1'b0);
      byte_x(dev | 8'h01, j, n2);
      byte_x(8'hFF, q, j[0]);
    end
    frame(1'b1);
    ok = !n0 && !n1 && !n2;
  endtask : xfer
endmodule : mmc_host_model

// [tb/tb.sv]
// Self-checking bench for the management block
`timescale 1ns/1ps
module tb;
  localparam int unsigned INIT = 100;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic sel_n = 1'b0;
  logic mrst_n = 1'b1;
  logic lp_req = 1'b0;
  logic [7:0] flt = 8'h00;
  logic scl, h_oe, oe, lp_st, int_oe, sda_out, prs_n, int_n, ok;
  logic [7:0] d, v;
  wire sda = !(h_oe || oe);
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h5DE15A0C;
  int exp_pg;
  always #2 REF_CLK = !REF_CLK;
  mmc_top #(.INIT_CYC(INIT)) mmc_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'b1), .MODULE_SELECT_N(sel_n),
    .MODULE_RESET_N(mrst_n), .LOW_POWER_REQUEST(lp_req), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(oe), .MODULE_PRESENT_N(prs_n), .INTERRUPT_OUT_N(int_n), .INTERRUPT_OUT_OE(int_oe),
    .LOW_POWER_STATE(lp_st), .FAULT_FLAGS(flt));
  mmc_host_model mmc_host_model_i (.scl(scl), .sda_oe(h_oe), .sda(sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : cyc
  task automatic look(input int n);
    cyc(n);
    #1;
  endtask : look
  task automatic wr(input logic [7:0] p, input logic [7:0] x);
    mmc_host_model_i.xfer(8'hA0, p, 1'b1, x, d, ok);
    chk(8'(ok), 8'h01);
  endtask : wr
  task automatic rd(input logic [7:0] p);
    mmc_host_model_i.xfer(8'hA0, p, 1'b0, 8'h00, d, ok);
    chk(8'(ok), 8'h01);
  endtask : rd
  task automatic print_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    cyc(6);
    RST_N <= 1'b1;
    look(INIT - 20);
    chk(8'(int_oe), 8'h00);
    look(40);
    chk(8'(int_oe), 8'h01);
    chk({5'h00, prs_n, int_n, sda_out}, 8'h00);
    rd(8'h02);
    chk(8'(d[0]), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      v[1:0] = i[1:0];
      exp_pg = v;
      wr(8'h7F, v);
      rd(8'h7F);
      chk(d, 8'(exp_pg));
    end
    wr(8'h85, 8'hA5);
    wr(8'h7F, 8'h00);
    wr(8'h85, 8'h5A);
    rd(8'h85);
    chk(d, 8'h5A);
    wr(8'h7F, 8'(exp_pg));
    rd(8'h85);
    chk(d, 8'hA5);
    rd(8'h77);
    chk(d, 8'h00);
    rd(8'h7B);
    chk(d, 8'h00);
    mmc_host_model_i.xfer(8'hA2, 8'h7F, 1'b1, 8'h00, d, ok);
    chk(8'(ok), 8'h00);
    cyc(2);
    sel_n <= 1'b1;
    cyc(4);
    mmc_host_model_i.xfer(8'hA0, 8'h7F, 1'b1, 8'h00, d, ok);
    chk(8'(ok), 8'h00);
    cyc(2);
    sel_n <= 1'b0;
    cyc(4);
    rd(8'h7F);
    chk(d, 8'(exp_pg));
    wr(8'h03, 8'hFF);
    look(4);
    chk(8'(int_oe), 8'h00);
    v = 8'($random(seed)) | 8'h01;
    cyc(1);
    flt <= v;
    cyc(1);
    flt <= 8'h00;
    look(4);
    chk(8'(int_oe), 8'h01);
    rd(8'h03);
    chk(d, v);
    wr(8'h03, 8'hFF);
    look(4);
    chk(8'(int_oe), 8'h00);
    cyc(1);
    lp_req <= 1'b1;
    look(8);
    chk(8'(lp_st), 8'h01);
    cyc(1);
    lp_req <= 1'b0;
    look(8);
    chk(8'(lp_st), 8'h00);
    wr(8'h56, 8'h01);
    look(4);
    chk(8'(lp_st), 8'h01);
    wr(8'h7F, 8'h03);
    cyc(1);
    mrst_n <= 1'b0;
    cyc(400);
    mrst_n <= 1'b1;
    cyc(10);
    rd(8'h7F);
    chk(d, 8'h03);
    cyc(1);
    mrst_n <= 1'b0;
    cyc(600);
    mrst_n <= 1'b1;
    look(INIT - 20);
    chk(8'(int_oe), 8'h00);
    look(40);
    chk(8'(int_oe), 8'h01);
    chk(8'(lp_st), 8'h00);
    rd(8'h7F);
    chk(d, 8'h00);
    rd(8'h02);
    chk(8'(d[0]), 8'h00);
    print_verdict();
  end
endmodule : tb
